// ---- core/i2cee_pkg.sv ----
package i2cee_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_KHZ     = 200000;
    localparam int unsigned PROG_TIME_TYP_MS = 4;
    localparam int unsigned PROG_TIME_MAX_MS = 10;
    // ms times kHz gives cycles directly
    localparam int unsigned PROG_CYCLES      = PROG_TIME_TYP_MS * CLK_FREQ_KHZ;
    localparam int unsigned PROG_CYCLES_MAX  = PROG_TIME_MAX_MS * CLK_FREQ_KHZ;

    // ------------------------------------------------------------
    // addressing and layout
    // ------------------------------------------------------------
    localparam logic [3:0]  MEM_TAG       = 4'hA;
    localparam logic [3:0]  PROT_TAG      = 4'h6;
    localparam int unsigned BYTE_W        = 8;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned OFF_W         = 4;
    localparam int unsigned PAGE_BYTES    = 16;
    localparam int unsigned MEM_BYTES     = 256;
    localparam int unsigned FIFO_DEPTH    = 4;
    localparam int unsigned PROT_NIB_BIT  = 3;
    localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
    localparam logic [3:0]  LAST_TX_BIT   = 4'h7;

    // ------------------------------------------------------------
    // pin sampling vector
    // ------------------------------------------------------------
    localparam int unsigned PIN_W     = 6;
    localparam int unsigned PIN_SCL   = 0;
    localparam int unsigned PIN_SDA   = 1;
    localparam int unsigned PIN_WP    = 2;
    localparam int unsigned PIN_STRAP = 3;

    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_ADDR  = 8'h02,
        ST_WORD  = 8'h04,
        ST_DATA  = 8'h08,
        ST_ACK   = 8'h10,
        ST_TX    = 8'h20,
        ST_TXACK = 8'h40,
        ST_WAIT  = 8'h80
    } i2cee_state_t;

endpackage

// ---- core/i2cee_fifo.sv ----
`timescale 1ns/100ps
module i2cee_fifo #(
    parameter int unsigned WIDTH = 12,
    parameter int unsigned DEPTH = 4
) (
    input  wire  logic             clk,
    input  wire  logic             rst_n,
    input  wire  logic             in_valid,
    output logic                   in_ready,
    input  wire  logic [WIDTH-1:0] in_data,
    output logic                   out_valid,
    input  wire  logic             out_ready,
    output logic [WIDTH-1:0]       out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    // extra pointer bit separates full from empty
    assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
    assign out_valid = (wr_q != rd_q);
    assign out_data  = mem_q[rd_q[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

endmodule

// ---- core/i2cee_slave.sv ----
`timescale 1ns/100ps
// Contract
// RL1: programming cycle finishes within 10 ms
// RL2: while programming, bus ignored, data released
// RL3: master waits power-up delay before access
// RL4: master drives clock, start and stop
// RL5: start is data fall, clock high
// RL6: stop is data rise, clock high
// RL7: data changes only while clock low
// RL8: slave address upper nibble must be 1010
// RL9: next three bits match the strap inputs
// RL10: address lsb one reads, zero writes
// RL11: acknowledge by pulling data low, ninth clock
// RL12: write mode acknowledges every following byte
// RL13: read mode sends byte, checks master acknowledge
// RL14: byte write sequence, stop starts programming
// RL15: page write takes up to 16 bytes
// RL16: page pointer increments only low bits
// RL17: over 16 bytes wraps inside page
// RL18: program all page bytes after stop only
// RL19: write protect input high blocks all writes
// RL20: increment touches lowest four address bits only
// RL21: no write address acknowledge while programming
// RL22: 0110 byte write sets one-time protect register
// RL23: protect register locks lower 128 bytes forever
module i2cee_slave #(
    parameter int unsigned PROG_CYCLES = i2cee_pkg::PROG_CYCLES,
    parameter int unsigned FIFO_DEPTH  = i2cee_pkg::FIFO_DEPTH
) (
    input  wire  logic clk,
    input  wire  logic rst_n,
    input  wire  logic scl_i,
    input  wire  logic sda_i,
    output logic       sda_o,
    output logic       sda_oe,
    input  wire  logic select_strap_bit0,
    input  wire  logic select_strap_bit1,
    input  wire  logic select_strap_bit2,
    input  wire  logic write_protect_i,
    output logic       prog_busy
);
    localparam int unsigned FW = i2cee_pkg::OFF_W + i2cee_pkg::BYTE_W;
    localparam i2cee_pkg::i2cee_state_t
        ST_IDLE  = i2cee_pkg::ST_IDLE,
        ST_ADDR  = i2cee_pkg::ST_ADDR,
        ST_WORD  = i2cee_pkg::ST_WORD,
        ST_DATA  = i2cee_pkg::ST_DATA,
        ST_ACK   = i2cee_pkg::ST_ACK,
        ST_TX    = i2cee_pkg::ST_TX,
        ST_TXACK = i2cee_pkg::ST_TXACK,
        ST_WAIT  = i2cee_pkg::ST_WAIT;

    if (PROG_CYCLES < 1 || PROG_CYCLES > i2cee_pkg::PROG_CYCLES_MAX) begin : g_chk
        $error("program cycle count outside 1 .. max write time");
    end

    // ------------------------------------------------------------
    // reset release and pin sampling
    // ------------------------------------------------------------
    logic [1:0]                  rst_sync_n_q;
    logic                        rst_core_n;
    logic [i2cee_pkg::PIN_W-1:0] pin_meta_q;
    logic [i2cee_pkg::PIN_W-1:0] pin_sync_q;
    logic                        scl_last_q;
    logic                        sda_last_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_n_q <= 2'h0;
        end else begin
            rst_sync_n_q <= {rst_sync_n_q[0], 1'b1};
        end
    end
    assign rst_core_n = rst_sync_n_q[1];

    // idle bus reads high, so clock and data sampling bits reset high
    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            pin_meta_q <= 6'h3;
            pin_sync_q <= 6'h3;
            scl_last_q <= 1'b1;
            sda_last_q <= 1'b1;
        end else begin
            pin_meta_q <= {select_strap_bit2, select_strap_bit1, select_strap_bit0,
                           write_protect_i, sda_i, scl_i};
            pin_sync_q <= pin_meta_q;
            scl_last_q <= pin_sync_q[i2cee_pkg::PIN_SCL];
            sda_last_q <= pin_sync_q[i2cee_pkg::PIN_SDA];
        end
    end

    logic       scl_s;
    logic       sda_s;
    logic       wp_s;
    logic [2:0] strap_s;
    logic       start_ev;
    logic       stop_ev;
    logic       scl_rise;
    logic       scl_fall;

    assign scl_s    = pin_sync_q[i2cee_pkg::PIN_SCL];
    assign sda_s    = pin_sync_q[i2cee_pkg::PIN_SDA];
    assign wp_s     = pin_sync_q[i2cee_pkg::PIN_WP];
    assign strap_s  = pin_sync_q[i2cee_pkg::PIN_STRAP +: 3];
    // data edges while clock high are framing, never data
    assign start_ev = scl_s && scl_last_q && sda_last_q && !sda_s; // RL5 RL7
    assign stop_ev  = scl_s && scl_last_q && !sda_last_q && sda_s; // RL6 RL7
    assign scl_rise = scl_s && !scl_last_q;
    assign scl_fall = !scl_s && scl_last_q;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    i2cee_pkg::i2cee_state_t  state_q;
    i2cee_pkg::i2cee_state_t  after_ack_q;
    logic [3:0]               bit_cnt_q;
    logic [7:0]               sh_q;
    logic [7:0]               ptr_q;
    logic                     prot_acc_q;
    logic                     m_ack_q;
    logic                     busy_q;
    logic                     prot_q = 1'b0;
    logic [7:0]               mem_q [i2cee_pkg::MEM_BYTES];
    logic                     rx_done;
    logic                     match_mem;
    logic                     match_prot;
    logic                     word_done;
    logic                     data_push;
    logic                     prot_hit;
    logic                     fifo_in_ready;
    logic                     fifo_out_valid;
    logic [FW-1:0]            fifo_out_data;
    logic [7:0]               rd_byte;

    assign rx_done    = scl_fall && (bit_cnt_q == i2cee_pkg::BITS_PER_BYTE);
    assign match_mem  = (sh_q[7:4] == i2cee_pkg::MEM_TAG)
                        && (sh_q[3:1] == strap_s); // RL8 RL9
    // protect register answers only until it is set, and only to writes
    assign match_prot = (sh_q[7:4] == i2cee_pkg::PROT_TAG) && (sh_q[3:1] == strap_s)
                        && !sh_q[0] && !prot_q; // RL22
    assign word_done  = (state_q == ST_WORD) && rx_done;
    assign data_push  = (state_q == ST_DATA) && rx_done && !prot_acc_q && fifo_in_ready;
    assign prot_hit   = (state_q == ST_DATA) && rx_done && prot_acc_q;
    assign rd_byte    = mem_q[ptr_q];

    // ------------------------------------------------------------
    // bus state machine
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            state_q     <= ST_IDLE;
            after_ack_q <= ST_IDLE;
            bit_cnt_q   <= 4'h0;
            sh_q        <= 8'h00;
            ptr_q       <= 8'h00;
            prot_acc_q  <= 1'b0;
            m_ack_q     <= 1'b0;
            sda_oe      <= 1'b0;
        end else if (busy_q) begin
            // write cycle: deaf and released, polls go unanswered
            state_q <= ST_IDLE; // RL2 RL21
            sda_oe  <= 1'b0;
        end else if (stop_ev) begin
            state_q <= ST_IDLE; // RL6
            sda_oe  <= 1'b0;
        end else if (start_ev) begin
            // repeated start also lands here
            state_q   <= ST_ADDR; // RL4 RL5
            bit_cnt_q <= 4'h0;
            sda_oe    <= 1'b0;
        end else begin
            case (state_q)
                ST_ADDR, ST_WORD, ST_DATA: begin
                    if (scl_rise && bit_cnt_q != i2cee_pkg::BITS_PER_BYTE) begin
                        sh_q      <= {sh_q[6:0], sda_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (rx_done) begin
                        state_q <= ST_ACK;
                        sda_oe  <= 1'b1; // RL11 RL12
                        if (state_q == ST_ADDR) begin
                            prot_acc_q  <= match_prot;
                            after_ack_q <= sh_q[0] ? ST_TX : ST_WORD; // RL10
                            if (!(match_mem || match_prot)) begin
                                state_q <= ST_WAIT; // RL8 RL9
                                sda_oe  <= 1'b0;
                            end
                        end else if (state_q == ST_WORD) begin
                            ptr_q       <= sh_q; // RL14
                            after_ack_q <= ST_DATA;
                        end else begin
                            after_ack_q <= ST_DATA; // RL15
                            if (data_push) begin
                                // low nibble wraps, page bits hold
                                ptr_q[3:0] <= ptr_q[3:0] + 4'h1; // RL16 RL17 RL20
                            end else if (!prot_hit) begin
                                // buffer full: refuse the byte
                                state_q <= ST_WAIT;
                                sda_oe  <= 1'b0;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        state_q   <= after_ack_q;
                        sda_oe    <= 1'b0;
                        if (after_ack_q == ST_TX) begin
                            sh_q   <= rd_byte;
                            ptr_q  <= ptr_q + 8'h01;
                            sda_oe <= !rd_byte[7];
                        end
                    end
                end
                ST_TX: begin
                    // shifts on the low phase only
                    if (scl_fall) begin
                        if (bit_cnt_q == i2cee_pkg::LAST_TX_BIT) begin
                            state_q <= ST_TXACK; // RL13
                            sda_oe  <= 1'b0;
                        end else begin
                            sh_q      <= {sh_q[6:0], 1'b0};
                            sda_oe    <= !sh_q[6]; // RL7
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                    end
                end
                ST_TXACK: begin
                    if (scl_rise) begin
                        m_ack_q <= !sda_s;
                    end else if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        if (m_ack_q) begin
                            state_q <= ST_TX; // RL13
                            sh_q    <= rd_byte;
                            ptr_q   <= ptr_q + 8'h01;
                            sda_oe  <= !rd_byte[7];
                        end else begin
                            state_q <= ST_WAIT; // RL13
                        end
                    end
                end
                ST_IDLE, ST_WAIT: begin
                    sda_oe <= 1'b0;
                end
                default: begin
                    state_q <= ST_IDLE;
                    sda_oe  <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            sda_o <= 1'b0;
        end else begin
            sda_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // page buffer, fed through the fifo
    // ------------------------------------------------------------
    logic [7:0]                        page_q [i2cee_pkg::PAGE_BYTES];
    logic [i2cee_pkg::PAGE_BYTES-1:0]  page_vld_q;
    logic [3:0]                        base_q;
    logic [i2cee_pkg::PAGE_BYTES-1:0]  wr_mask;
    logic                              commit_q;

    // drain stalls during the write cycle; the bus is then deaf anyway
    i2cee_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_core_n),
        .in_valid  (data_push),
        .in_ready  (fifo_in_ready),
        .in_data   ({ptr_q[3:0], sh_q}),
        .out_valid (fifo_out_valid),
        .out_ready (!busy_q),
        .out_data  (fifo_out_data)
    );

    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            page_vld_q <= '0;
            base_q     <= 4'h0;
        end else if (word_done) begin
            page_vld_q <= '0;
            base_q     <= sh_q[7:4];
        end else if (commit_q) begin
            page_vld_q <= '0;
        end else if (fifo_out_valid && !busy_q) begin
            // later bytes at a wrapped offset overwrite earlier ones
            page_vld_q[fifo_out_data[FW-1 -: 4]] <= 1'b1; // RL17
        end
    end

    always_ff @(posedge clk) begin
        if (fifo_out_valid && !busy_q) begin
            page_q[fifo_out_data[FW-1 -: 4]] <= fifo_out_data[7:0];
        end
    end

    // ------------------------------------------------------------
    // write cycle timer and commit
    // ------------------------------------------------------------
    logic        wr_pend_q;
    logic        prot_pend_q;
    logic        prog_req_q;
    logic [31:0] prog_cnt_q;

    always_ff @(posedge clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            wr_pend_q   <= 1'b0;
            prot_pend_q <= 1'b0;
            prog_req_q  <= 1'b0;
            busy_q      <= 1'b0;
            commit_q    <= 1'b0;
            prog_cnt_q  <= 32'h0;
        end else begin
            commit_q <= 1'b0;
            // pending flags outlive the last busy cycle so the commit sees them
            if (commit_q) begin
                wr_pend_q   <= 1'b0;
                prot_pend_q <= 1'b0;
            end
            if (data_push) begin
                wr_pend_q <= 1'b1;
            end
            if (prot_hit) begin
                prot_pend_q <= 1'b1;
            end
            if (start_ev && !busy_q) begin
                // a new command abandons data not closed by stop
                wr_pend_q   <= data_push;
                prot_pend_q <= 1'b0;
            end
            if (stop_ev && !busy_q && !commit_q && (wr_pend_q || prot_pend_q)) begin
                prog_req_q <= 1'b1; // RL14 RL18
            end
            if (prog_req_q && !fifo_out_valid) begin
                prog_req_q <= 1'b0;
                busy_q     <= 1'b1;
                prog_cnt_q <= 32'h0;
            end else if (busy_q) begin
                prog_cnt_q <= prog_cnt_q + 32'h1;
                if (prog_cnt_q == PROG_CYCLES - 1) begin
                    busy_q      <= 1'b0; // RL1
                    commit_q    <= 1'b1;
                end
            end
        end
    end
    assign prog_busy = busy_q;

    for (genvar i = 0; i < i2cee_pkg::PAGE_BYTES; i++) begin : g_mask
        assign wr_mask[i] = commit_q && wr_pend_q && page_vld_q[i] && !wp_s // RL19
                            && !(prot_q && !base_q[i2cee_pkg::PROT_NIB_BIT]); // RL23
    end

    // whole page lands in one cycle
    always_ff @(posedge clk) begin
        for (int i = 0; i < i2cee_pkg::PAGE_BYTES; i++) begin
            if (wr_mask[i]) begin
                mem_q[{base_q, 4'(i)}] <= page_q[i]; // RL18
            end
        end
    end

    // nonvolatile flag: deliberately outside any reset
    always_ff @(posedge clk) begin
        if (commit_q && prot_pend_q && !wp_s) begin
            prot_q <= 1'b1; // RL22 RL23
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_core_n);

    a_prog_bounded: assert property ( // RL1
        busy_q |-> prog_cnt_q < PROG_CYCLES)
        else $error("write cycle ran past its length");
    a_busy_quiet: assert property ( // RL2 RL21
        busy_q |-> !sda_oe && state_q == ST_IDLE)
        else $error("bus answered during write cycle");
    a_start_addr: assert property ( // RL5
        start_ev && !busy_q |=> state_q == ST_ADDR && !sda_oe)
        else $error("start not followed by address phase");
    a_stop_idle: assert property ( // RL6
        stop_ev |=> state_q == ST_IDLE && !sda_oe)
        else $error("stop did not return to idle");
    a_addr_reject: assert property ( // RL8 RL9
        state_q == ST_ADDR && rx_done && !busy_q && !start_ev && !stop_ev
        && !match_mem && !match_prot |=> state_q == ST_WAIT && !sda_oe)
        else $error("foreign address acknowledged");
    a_addr_ack: assert property ( // RL11 RL12
        state_q == ST_ADDR && rx_done && !busy_q && match_mem
        |=> sda_oe && state_q == ST_ACK)
        else $error("own address not acknowledged");
    a_dir_read: assert property ( // RL10
        state_q == ST_ACK && after_ack_q == ST_TX && scl_fall && !busy_q
        && !stop_ev |=> state_q == ST_TX)
        else $error("read direction did not transmit");
    a_page_wrap: assert property ( // RL16 RL20
        data_push && !busy_q |=> ptr_q[7:4] == $past(ptr_q[7:4])
        && ptr_q[3:0] == 4'($past(ptr_q[3:0]) + 4'h1))
        else $error("page pointer moved outside page");
    a_stop_prog: assert property ( // RL18 RL14
        stop_ev && !busy_q && !commit_q && wr_pend_q |=> prog_req_q ##[1:8] busy_q)
        else $error("stop did not start write cycle");
    a_wp_block: assert property ( // RL19
        commit_q && wp_s |-> wr_mask == '0)
        else $error("write through protect input");
    a_tx_nack: assert property ( // RL13
        state_q == ST_TXACK && scl_fall && !m_ack_q && !busy_q |=> state_q == ST_WAIT)
        else $error("transmit went on without acknowledge");

    c_page_commit: cover property (commit_q && wr_pend_q && (&page_vld_q));
    c_read_more:   cover property (state_q == ST_TXACK && scl_fall && m_ack_q);
    c_prot_set:    cover property (commit_q && prot_pend_q && !wp_s);
    c_fifo_full:   cover property (!fifo_in_ready);

endmodule

// ---- bench/i2cee_bus_master.sv ----
`timescale 1ns/100ps
module i2cee_bus_master (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    // ------------------------------------------------------------
    // bus phases, 64 ns per bit
    // ------------------------------------------------------------
    // clock idles high between frames and never runs free
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic put_bit(input logic v);
        #16 sda_pull = ~v;
        #16 scl = 1'b1;
        #32 scl = 1'b0;
    endtask

    // late clock rise leaves room for the slave to let go of data
    task automatic start;
        sda_pull = 1'b0;
        #32 scl = 1'b1;
        #16 sda_pull = 1'b1;
        #16 scl = 1'b0;
    endtask

    task automatic stop;
        #16 sda_pull = 1'b1;
        #16 scl = 1'b1;
        #16 sda_pull = 1'b0;
        #32;
    endtask

    task automatic wr(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i]);
        end
        #16 sda_pull = 1'b0;
        #16 scl = 1'b1;
        #16 ack = ~sda;
        #16 scl = 1'b0;
    endtask

    task automatic rd(input logic last, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            #16 sda_pull = 1'b0;
            #16 scl = 1'b1;
            #16 b[i] = sda;
            #16 scl = 1'b0;
        end
        put_bit(last);
    endtask
endmodule

// ---- bench/i2c_eeprom_slave_write_path_bench.sv ----
`timescale 1ns/100ps
module i2c_eeprom_slave_write_path_bench;
    // ------------------------------------------------------------
    // setup
    // ------------------------------------------------------------
    // short write cycle keeps the run small, still longer than a poll
    localparam int unsigned PROG = 400;
    typedef struct packed {
        logic [7:0] addr;
        logic       ack;
    } i2cee_row_t;
    // straps are 101: of these rows only 8'hAA selects this device for writing
    localparam i2cee_row_t ROWS [6] = '{'{8'hAA, 1'b1}, '{8'hA8, 1'b0}, '{8'hAE, 1'b0},
                                        '{8'hA2, 1'b0}, '{8'hBA, 1'b0}, '{8'h2A, 1'b0}};
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       scl;
    logic       pull;
    logic       sda_oe;
    logic [2:0] strap = 3'h5;
    logic       wp = 1'b0;
    logic       prog_busy;
    logic       sda_out;
    logic       locked = 1'b0;
    wire logic  sda = ~(sda_oe | pull);
    logic [7:0] mem [256];
    int         fails = 0;
    int         n_checks = 0;
    int         busy_len = 0;
    int         busy_run = 0;

    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (prog_busy === 1'b1) begin
            busy_run <= busy_run + 1;
        end else begin
            if (busy_run != 0) busy_len <= busy_run;
            busy_run <= 0;
        end
    end

    i2cee_slave #(.PROG_CYCLES(PROG), .FIFO_DEPTH(4)) i_dut (
        .clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_out), .sda_oe(sda_oe),
        .select_strap_bit0(strap[0]), .select_strap_bit1(strap[1]),
        .select_strap_bit2(strap[2]), .write_protect_i(wp), .prog_busy(prog_busy));
    i2cee_bus_master i_mst (.scl(scl), .sda_pull(pull), .sda(sda));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("mismatch %s exp %h got %h", what, exp, got);
            fails++;
        end
    endtask

    task automatic end_of_test;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic wait_rise(output logic rose);
        rose = 1'b0;
        for (int i = 0; i < 40 && !rose; i++) begin
            @(negedge clk);
            rose = (prog_busy === 1'b1);
        end
    endtask

    task automatic wait_fall;
        for (int i = 0; i < 1000 && prog_busy !== 1'b0; i++) @(negedge clk);
        @(negedge clk);
    endtask

    task automatic wr_seq(input logic [7:0] word, input int n, input logic [7:0] d0);
        logic ack;
        i_mst.start();
        i_mst.wr(8'hAA, ack);
        chk("addr ack", 1, ack);
        i_mst.wr(word, ack);
        chk("word ack", 1, ack);
        for (int i = 0; i < n; i++) begin
            i_mst.wr(d0 + 8'(i), ack);
            chk("data ack", 1, ack);
            if (wp === 1'b0 && !(locked && !word[7])) begin
                mem[{word[7:4], word[3:0] + 4'(i)}] = d0 + 8'(i);
            end
        end
        i_mst.stop();
    endtask

    task automatic rd_seq(input logic [7:0] word, input int n);
        logic       ack;
        logic [7:0] d;
        i_mst.start();
        i_mst.wr(8'hAA, ack);
        chk("ready ack", 1, ack);
        i_mst.wr(word, ack);
        i_mst.start();
        i_mst.wr(8'hAB, ack);
        chk("read ack", 1, ack);
        for (int i = 0; i < n; i++) begin
            i_mst.rd(i == n - 1, d);
            chk("read data", mem[word + 8'(i)], d);
        end
        i_mst.stop();
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic ack;
        logic rose;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        foreach (ROWS[k]) begin
            i_mst.start();
            i_mst.wr(ROWS[k].addr, ack);
            chk("row ack", ROWS[k].ack, ack);
            i_mst.stop();
        end
        wr_seq(8'h35, 1, 8'h5A);
        wait_rise(rose);
        chk("busy rise", 1, rose);
        i_mst.start();
        i_mst.wr(8'hAA, ack);
        chk("poll ack", 0, ack);
        i_mst.stop();
        wait_fall();
        chk("busy cycles", PROG, busy_len);
        rd_seq(8'h35, 1);
        // 17 bytes from offset E: the last one lands on E again
        wr_seq(8'h2E, 17, 8'h40);
        wait_rise(rose);
        wait_fall();
        rd_seq(8'h20, 16);
        @(negedge clk) wp = 1'b1;
        wr_seq(8'h35, 1, 8'hA5);
        wait_rise(rose);
        wait_fall();
        @(negedge clk) wp = 1'b0;
        rd_seq(8'h35, 1);
        // one-time protect write, then the lower half stays locked
        i_mst.start();
        i_mst.wr(8'h6A, ack);
        chk("prot ack", 1, ack);
        i_mst.wr(8'h00, ack);
        i_mst.wr(8'h00, ack);
        i_mst.stop();
        wait_rise(rose);
        wait_fall();
        locked = 1'b1;
        wr_seq(8'h35, 1, 8'hC3);
        wait_rise(rose);
        wait_fall();
        rd_seq(8'h35, 1);
        wr_seq(8'h90, 1, 8'h11);
        wait_rise(rose);
        @(negedge clk) rst_n = 1'b0;
        #1;
        chk("reset busy", 0, prog_busy);
        chk("reset oe", 0, sda_oe);
        chk("reset sda_o", 0, sda_out);
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        // aborted write leaves the bus usable, the protect flag survives
        i_mst.start();
        i_mst.wr(8'hAA, ack);
        chk("reset ack", 1, ack);
        i_mst.stop();
        i_mst.start();
        i_mst.wr(8'h6A, ack);
        chk("prot refused", 0, ack);
        i_mst.stop();
        end_of_test();
    end

    initial begin
        #150000;
        fails++;
        end_of_test();
    end
endmodule
